// >>> verilog/qpsd_defs.svh
`ifndef QPSD_DEFS_SVH
`define QPSD_DEFS_SVH

// register locations carried in the command byte
`define QPSD_LOC_WIPER0 4'h0
`define QPSD_LOC_WIPER1 4'h1
`define QPSD_LOC_TCON0 4'h4
`define QPSD_LOC_WIPER2 4'h6
`define QPSD_LOC_WIPER3 4'h7
`define QPSD_LOC_TCON1 4'hA

// operation codes
`define QPSD_OP_WRITE 2'h0
`define QPSD_OP_INC 2'h1
`define QPSD_OP_DEC 2'h2
`define QPSD_OP_READ 2'h3

// storage slots of the register file
`define QPSD_SLOT_WIPER0 3'h0
`define QPSD_SLOT_WIPER1 3'h1
`define QPSD_SLOT_WIPER2 3'h2
`define QPSD_SLOT_WIPER3 3'h3
`define QPSD_SLOT_TCON0 3'h4
`define QPSD_SLOT_TCON1 3'h5
`define QPSD_SLOT_COUNT 6

// bit positions inside a frame
`define QPSD_POS_HDR_LAST 4'h5
`define QPSD_POS_FLAG 4'h6
`define QPSD_POS_CMD_LAST 4'h7
`define QPSD_POS_DATA_FIRST 4'h8
`define QPSD_POS_DATA_LAST 4'hF

// values
`define QPSD_WIPER_FULL 9'h100
`define QPSD_WIPER_RST 9'h000
`define QPSD_TERMINAL_CONNECT_REGISTER_RST 9'h000
// pin idle levels in sync order: select high, high-voltage low, clock low, data low
`define QPSD_PIN_IDLE 4'h8
`define QPSD_NV_LOC_MASK 16'h0000

`endif

// >>> verilog/qpsd_pkg.sv
`include "qpsd_defs.svh"

package qpsd_pkg;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_CMD = 4'h2,
		ST_DATA = 4'h4,
		ST_ERR = 4'h8
	} qpsd_state_e;

	typedef enum logic [1:0] {
		OP_WRITE = `QPSD_OP_WRITE,
		OP_INC = `QPSD_OP_INC,
		OP_DEC = `QPSD_OP_DEC,
		OP_READ = `QPSD_OP_READ
	} qpsd_op_e;

	typedef logic [2:0] qpsd_slot_t;
	typedef logic [8:0] qpsd_word_t;

	function automatic logic qpsd_is_wiper(input logic [3:0] loc);
		return (loc == `QPSD_LOC_WIPER0) || (loc == `QPSD_LOC_WIPER1) ||
			(loc == `QPSD_LOC_WIPER2) || (loc == `QPSD_LOC_WIPER3);
	endfunction : qpsd_is_wiper

	function automatic logic qpsd_is_term(input logic [3:0] loc);
		return (loc == `QPSD_LOC_TCON0) || (loc == `QPSD_LOC_TCON1);
	endfunction : qpsd_is_term

	function automatic qpsd_slot_t qpsd_loc_slot(input logic [3:0] loc);
		qpsd_slot_t s;
		s = `QPSD_SLOT_WIPER0;
		unique case (loc)
			`QPSD_LOC_WIPER1: s = `QPSD_SLOT_WIPER1;
			`QPSD_LOC_WIPER2: s = `QPSD_SLOT_WIPER2;
			`QPSD_LOC_WIPER3: s = `QPSD_SLOT_WIPER3;
			`QPSD_LOC_TCON0: s = `QPSD_SLOT_TCON0;
			`QPSD_LOC_TCON1: s = `QPSD_SLOT_TCON1;
			default: s = `QPSD_SLOT_WIPER0;
		endcase
		return s;
	endfunction : qpsd_loc_slot

	// wipers take every operation, terminal-connect only read and write
	function automatic logic qpsd_pair_ok(input logic [3:0] loc, input logic [1:0] op);
		return qpsd_is_wiper(loc) ||
			(qpsd_is_term(loc) && (op == `QPSD_OP_READ || op == `QPSD_OP_WRITE));
	endfunction : qpsd_pair_ok

endpackage : qpsd_pkg

// >>> verilog/qpsd_reg_if.sv
`timescale 1ns/10ps
`include "qpsd_defs.svh"

interface qpsd_reg_if;
	import qpsd_pkg::*;
	logic wr;
	logic inc;
	logic dec;
	qpsd_slot_t slot;
	qpsd_word_t wdata;
	logic [`QPSD_SLOT_COUNT-1:0][8:0] vals;

	modport ctrl (output wr, output inc, output dec, output slot, output wdata, input vals);
	modport regs (input wr, input inc, input dec, input slot, input wdata, output vals);
endinterface : qpsd_reg_if

// >>> verilog/qpsd_sync.sv
`timescale 1ns/10ps
`include "qpsd_defs.svh"

module qpsd_sync
	import qpsd_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [3:0] d_i,
	output logic [3:0] q_o
);

	logic [3:0] meta_ff;
	logic [3:0] sync_ff;
	// reset to idle levels, else a false select edge would follow reset
	localparam logic [3:0] PIN_IDLE = `QPSD_PIN_IDLE;

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_bit
			always_ff @(posedge clk_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					meta_ff[g] <= PIN_IDLE[g];
					sync_ff[g] <= PIN_IDLE[g];
				end else begin
					meta_ff[g] <= d_i[g];
					sync_ff[g] <= meta_ff[g];
				end
			end
		end
	endgenerate

	assign q_o = sync_ff;

endmodule : qpsd_sync

// >>> verilog/qpsd_regfile.sv
`timescale 1ns/10ps
`include "qpsd_defs.svh"

module qpsd_regfile
	import qpsd_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	qpsd_reg_if.regs rif
);

	logic [8:0] val_ff [`QPSD_SLOT_COUNT];

	genvar g;
	generate
		for (g = 0; g < `QPSD_SLOT_COUNT; g++) begin : g_slot
			localparam logic [8:0] RST_VAL = (g >= 4) ? `QPSD_TERMINAL_CONNECT_REGISTER_RST : `QPSD_WIPER_RST;
			logic hit;
			assign hit = (rif.slot == 3'(g));
			always_ff @(posedge clk_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					val_ff[g] <= RST_VAL;
				end else if (hit && rif.wr) begin
					// all nine bits kept, so values past full scale are accepted
					val_ff[g] <= rif.wdata;
				end else if (hit && rif.inc && val_ff[g] < `QPSD_WIPER_FULL) begin
					val_ff[g] <= val_ff[g] + 9'h001;
				end else if (hit && rif.dec && val_ff[g] != 9'h000) begin
					val_ff[g] <= val_ff[g] - 9'h001;
				end
			end
			assign rif.vals[g] = val_ff[g];
		end
	endgenerate

endmodule : qpsd_regfile

// >>> verilog/qpsd_cmd_decoder.sv
`timescale 1ns/10ps
`include "qpsd_defs.svh"

module qpsd_cmd_decoder
	import qpsd_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic cs_b_i,
	input wire logic cs_hv_i,
	input wire logic sck_i,
	input wire logic sdi_i,
	output logic sdo_o,
	output logic sdo_oe_b_o,
	output logic hv_cmd_o,
	output logic cmd_fault_flag_o,
	output logic [8:0] wiper0_o,
	output logic [8:0] wiper1_o,
	output logic [8:0] wiper2_o,
	output logic [8:0] wiper3_o,
	output logic [8:0] tcon0_o,
	output logic [8:0] tcon1_o
);

	////////////////////////////////////////////////////////////////////////////////
	// pin sampling

	logic [3:0] sync_q;
	logic cs_b_s;
	logic cs_hv_s;
	logic sck_s;
	logic sdi_s;
	logic cs_act;
	logic cs_act_d_ff;
	logic sck_d_ff;
	logic cs_on;
	logic cs_off;
	logic sck_rise;
	logic sck_fall;

	qpsd_sync u_sync (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.d_i({cs_b_i, cs_hv_i, sck_i, sdi_i}),
		.q_o(sync_q)
	);

	assign {cs_b_s, cs_hv_s, sck_s, sdi_s} = sync_q;
	// both select levels frame a command
	assign cs_act = ~cs_b_s | cs_hv_s;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cs_act_d_ff <= 1'b0;
			sck_d_ff <= 1'b0;
		end else begin
			cs_act_d_ff <= cs_act;
			sck_d_ff <= sck_s;
		end
	end

	assign cs_on = cs_act & ~cs_act_d_ff;
	assign cs_off = ~cs_act & cs_act_d_ff;
	// all pins share the sync latency, so data stays aligned with its clock edge
	assign sck_rise = sck_s & ~sck_d_ff;
	assign sck_fall = ~sck_s & sck_d_ff;

	////////////////////////////////////////////////////////////////////////////////
	// frame state

	qpsd_state_e state_ff;
	logic [3:0] cnt_ff;
	logic [7:0] sh_ff;
	logic [7:0] sh_in;
	logic [3:0] hdr_loc;
	logic [1:0] hdr_op;
	logic hdr_ok;
	logic [3:0] loc_ff;
	qpsd_op_e op_ff;
	logic data_bit_eight_ff;
	logic flag_ff;
	logic nv_pend_ff;
	logic [8:0] rd_ff;
	logic hv_ff;
	logic take;
	logic short_op;
	localparam logic [15:0] NV_LOC_MASK = `QPSD_NV_LOC_MASK;

	assign sh_in = {sh_ff[6:0], sdi_s};
	assign hdr_loc = sh_in[5:2];
	assign hdr_op = sh_in[1:0];
	// a pending nonvolatile write turns any following header into a fault
	assign hdr_ok = qpsd_pair_ok(hdr_loc, hdr_op) & ~nv_pend_ff;
	assign take = sck_rise & cs_act & ~cs_on;
	assign short_op = (op_ff == OP_INC) || (op_ff == OP_DEC);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_ff <= ST_IDLE;
			cnt_ff <= 4'h0;
		end else if (cs_on) begin
			state_ff <= ST_CMD;
			cnt_ff <= 4'h0;
		end else if (!cs_act) begin
			// release drops any partial command
			state_ff <= ST_IDLE;
			cnt_ff <= 4'h0;
		end else if (take) begin
			unique case (state_ff)
				ST_IDLE: begin
					state_ff <= ST_IDLE;
				end
				ST_CMD: begin
					if (cnt_ff == `QPSD_POS_HDR_LAST && !hdr_ok) begin
						state_ff <= ST_ERR;
						cnt_ff <= cnt_ff + 4'h1;
					end else if (cnt_ff == `QPSD_POS_CMD_LAST && short_op) begin
						cnt_ff <= 4'h0;
					end else if (cnt_ff == `QPSD_POS_CMD_LAST) begin
						state_ff <= ST_DATA;
						cnt_ff <= `QPSD_POS_DATA_FIRST;
					end else begin
						cnt_ff <= cnt_ff + 4'h1;
					end
				end
				ST_DATA: begin
					if (cnt_ff == `QPSD_POS_DATA_LAST) begin
						state_ff <= ST_CMD;
						cnt_ff <= 4'h0;
					end else begin
						cnt_ff <= cnt_ff + 4'h1;
					end
				end
				ST_ERR: begin
					state_ff <= ST_ERR;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sh_ff <= 8'h00;
		end else if (cs_on) begin
			sh_ff <= 8'h00;
		end else if (take && (state_ff == ST_CMD || state_ff == ST_DATA)) begin
			sh_ff <= sh_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// header decode and read capture

	qpsd_reg_if reg_if ();

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			loc_ff <= 4'h0;
			op_ff <= OP_READ;
			flag_ff <= 1'b1;
			rd_ff <= 9'h000;
			data_bit_eight_ff <= 1'b0;
		end else if (cs_on) begin
			flag_ff <= 1'b1;
		end else if (take && state_ff == ST_CMD && cnt_ff == `QPSD_POS_HDR_LAST) begin
			loc_ff <= hdr_loc;
			op_ff <= qpsd_op_e'(hdr_op);
			flag_ff <= hdr_ok;
			rd_ff <= reg_if.vals[qpsd_loc_slot(hdr_loc)];
		end else if (take && state_ff == ST_CMD && cnt_ff == `QPSD_POS_CMD_LAST) begin
			data_bit_eight_ff <= sdi_s;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			nv_pend_ff <= 1'b0;
			hv_ff <= 1'b0;
		end else if (cs_on) begin
			nv_pend_ff <= 1'b0;
			hv_ff <= cs_hv_s;
		end else if (!cs_act) begin
			nv_pend_ff <= 1'b0;
		end else if (reg_if.wr && NV_LOC_MASK[loc_ff]) begin
			nv_pend_ff <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// execution strobes

	// nothing runs before the last bit of its own byte has been counted
	assign reg_if.inc = take && state_ff == ST_CMD && cnt_ff == `QPSD_POS_CMD_LAST &&
		op_ff == OP_INC;
	assign reg_if.dec = take && state_ff == ST_CMD && cnt_ff == `QPSD_POS_CMD_LAST &&
		op_ff == OP_DEC;
	assign reg_if.wr = take && state_ff == ST_DATA && cnt_ff == `QPSD_POS_DATA_LAST &&
		op_ff == OP_WRITE;
	// data bit nine is taken from the last bit of the command byte
	assign reg_if.wdata = {data_bit_eight_ff, sh_in[7:0]};
	assign reg_if.slot = qpsd_loc_slot(loc_ff);

	qpsd_regfile u_regs (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.rif(reg_if)
	);

	////////////////////////////////////////////////////////////////////////////////
	// serial output

	logic nxt_sdo;
	logic [3:0] rd_idx;
	logic sdo_ff;
	logic oe_b_ff;

	assign rd_idx = `QPSD_POS_DATA_LAST - cnt_ff;

	always_comb begin
		nxt_sdo = 1'b1;
		unique case (state_ff)
			ST_IDLE: nxt_sdo = 1'b1;
			ST_ERR: nxt_sdo = 1'b0;
			ST_CMD, ST_DATA: begin
				if (cnt_ff < `QPSD_POS_FLAG) begin
					nxt_sdo = 1'b1;
				end else if (cnt_ff == `QPSD_POS_FLAG) begin
					nxt_sdo = flag_ff;
				end else if (op_ff == OP_READ) begin
					nxt_sdo = rd_ff[rd_idx];
				end else begin
					nxt_sdo = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sdo_ff <= 1'b1;
			oe_b_ff <= 1'b1;
		end else if (cs_on) begin
			sdo_ff <= 1'b1;
			oe_b_ff <= 1'b0;
		end else if (!cs_act) begin
			sdo_ff <= 1'b1;
			oe_b_ff <= 1'b1;
		end else if (sck_fall) begin
			sdo_ff <= nxt_sdo;
		end
	end

	assign sdo_o = sdo_ff;
	assign sdo_oe_b_o = oe_b_ff;
	assign hv_cmd_o = hv_ff;
	assign cmd_fault_flag_o = flag_ff;
	assign wiper0_o = reg_if.vals[`QPSD_SLOT_WIPER0];
	assign wiper1_o = reg_if.vals[`QPSD_SLOT_WIPER1];
	assign wiper2_o = reg_if.vals[`QPSD_SLOT_WIPER2];
	assign wiper3_o = reg_if.vals[`QPSD_SLOT_WIPER3];
	assign tcon0_o = reg_if.vals[`QPSD_SLOT_TCON0];
	assign tcon1_o = reg_if.vals[`QPSD_SLOT_TCON1];

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence s_select;
		cs_on;
	endsequence

	sequence s_armed;
		state_ff == ST_CMD && cnt_ff == 4'h0 && !sdo_oe_b_o;
	endsequence

	a_select_start: assert property (s_select |=> s_armed)
		else $error("select did not arm the frame");

	a_release_idle: assert property (cs_off |=> state_ff == ST_IDLE && sdo_oe_b_o)
		else $error("release did not reset the interface");

	a_idle_quiet: assert property (state_ff == ST_IDLE && !cs_on |=>
		$stable(reg_if.vals))
		else $error("registers changed while deselected");

	a_fault_hold: assert property (state_ff == ST_ERR && cs_act |=>
		state_ff == ST_ERR && !reg_if.wr && !reg_if.inc && !reg_if.dec)
		else $error("fault state left while selected");

	a_fault_low: assert property (state_ff == ST_ERR && sck_fall && cs_act |=> !sdo_o)
		else $error("output not low after a fault");

	a_head_ones: assert property (state_ff == ST_CMD && cnt_ff < 4'h6 && sck_fall &&
		cs_act |=> sdo_o)
		else $error("header bit not high");

	a_flag_slot: assert property (cnt_ff == 4'h6 && sck_fall && cs_act &&
		state_ff != ST_IDLE |=> sdo_o == flag_ff)
		else $error("flag not driven at seventh bit");

	a_step_wiper: assert property (reg_if.inc || reg_if.dec |->
		qpsd_is_wiper(loc_ff))
		else $error("step reached a non-wiper location");

	a_write_full: assert property (reg_if.wr |-> cnt_ff == 4'hF && state_ff == ST_DATA &&
		op_ff == OP_WRITE)
		else $error("write strobe off the sixteenth bit");

	a_write_lands: assert property (reg_if.wr |=>
		reg_if.vals[$past(reg_if.slot)] == $past(reg_if.wdata))
		else $error("written value not stored");

	a_bad_pair: assert property (take && state_ff == ST_CMD && cnt_ff == 4'h5 &&
		!qpsd_pair_ok(hdr_loc, hdr_op) |=> state_ff == ST_ERR && !flag_ff)
		else $error("invalid pair not faulted");

endmodule : qpsd_cmd_decoder

// >>> bench/qpsd_spi_host.sv
`timescale 1ns/10ps

module qpsd_spi_host (
	input wire logic clk_i,
	input wire logic sdo_i,
	input wire logic sdo_oe_b_i,
	output logic cs_b_o,
	output logic cs_hv_o,
	output logic sck_o,
	output logic sdi_o,
	output logic done_o,
	output logic [31:0] rx_o
);
	logic busy;

	initial begin
		cs_b_o = 1'b1;
		cs_hv_o = 1'b0;
		sck_o = 1'b0;
		sdi_o = 1'b0;
		done_o = 1'b0;
		rx_o = '0;
		busy = 1'b0;
	end

	// an undriven data line keeps toggling so a stale bit never looks valid
	always @(negedge clk_i) begin
		if (!busy) begin
			sdi_o <= ~sdi_o;
		end
	end

	task automatic wait_clk(input int n);
		repeat (n) @(negedge clk_i);
	endtask : wait_clk

	// frames stay short, at most four bytes, and select drops right after
	task automatic frame(input logic [31:0] tx, input int n, input logic hv);
		busy = 1'b1;
		rx_o = '0;
		wait_clk(1);
		cs_hv_o = hv;
		cs_b_o = hv;
		wait_clk(5);
		for (int k = 0; k < n; k++) begin
			sdi_o = tx[31-k];
			wait_clk(4);
			sck_o = 1'b1;
			wait_clk(4);
			rx_o[31-k] = (sdo_oe_b_i === 1'b0) ? sdo_i : 1'bx;
			sck_o = 1'b0;
		end
		wait_clk(3);
		done_o = 1'b1;
		wait_clk(1);
		done_o = 1'b0;
		cs_b_o = 1'b1;
		cs_hv_o = 1'b0;
		busy = 1'b0;
		wait_clk(6);
	endtask : frame

	// clock pulses while deselected, sck idles low otherwise
	task automatic stray_clocks(input int n);
		repeat (n) begin
			sck_o = 1'b1;
			wait_clk(4);
			sck_o = 1'b0;
			wait_clk(4);
		end
	endtask : stray_clocks
endmodule : qpsd_spi_host

// >>> bench/qpsd_cmd_decoder_tb.sv
`timescale 1ns/10ps

module qpsd_cmd_decoder_tb;
	import qpsd_pkg::*;

	typedef struct {
		logic [31:0] rx;
		int n;
		logic hv;
		logic flag;
		logic [5:0][8:0] regs;
	} qpsd_exp_s;

	logic clk_i;
	logic rst_b_i;
	logic cs_b, cs_hv, sck, sdi, sdo, sdo_oe_b, hv_cmd, flag, done;
	logic [31:0] rx;
	logic [5:0][8:0] regs_seen;
	logic [5:0][8:0] model = '0;
	qpsd_exp_s exp_q[$];
	qpsd_exp_s mon_e;
	int fails = 0;
	int samples_checked = 0;
	int cycles = 0;

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	qpsd_cmd_decoder i_qpsd_cmd_decoder (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b), .cs_hv_i(cs_hv), .sck_i(sck),
		.sdi_i(sdi), .sdo_o(sdo), .sdo_oe_b_o(sdo_oe_b), .hv_cmd_o(hv_cmd),
		.cmd_fault_flag_o(flag), .wiper0_o(regs_seen[0]), .wiper1_o(regs_seen[1]),
		.wiper2_o(regs_seen[2]), .wiper3_o(regs_seen[3]), .tcon0_o(regs_seen[4]),
		.tcon1_o(regs_seen[5])
	);

	qpsd_spi_host i_qpsd_spi_host (
		.clk_i(clk_i), .sdo_i(sdo), .sdo_oe_b_i(sdo_oe_b), .cs_b_o(cs_b), .cs_hv_o(cs_hv),
		.sck_o(sck), .sdi_o(sdi), .done_o(done), .rx_o(rx)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
		samples_checked++;
		if (seen !== want) begin
			fails++;
			$display("Error at %0t: %s seen %h expected %h", $time, what, seen, want);
		end
	endtask : check

	task automatic close_out();
		if (fails == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : close_out

	function automatic int slot_of(input logic [3:0] loc);
		case (loc)
			4'h0: return 0;
			4'h1: return 1;
			4'h6: return 2;
			4'h7: return 3;
			4'h4: return 4;
			4'hA: return 5;
			default: return -1;
		endcase
	endfunction : slot_of

	// predicts the serial answer and register state, then runs the frame
	task automatic send(input logic [31:0] tx, input int n, input logic hv);
		qpsd_exp_s e;
		int p;
		int s;
		int len;
		logic ok;
		logic flt;
		logic [1:0] op;
		e.rx = '0;
		e.n = n;
		e.hv = hv;
		flt = 1'b0;
		p = 0;
		while (p < n) begin
			s = slot_of(tx[31-p -: 4]);
			op = tx[27-p -: 2];
			ok = !flt && s >= 0 && (s < 4 || op == 2'b11 || op == 2'b00);
			len = (op == 2'b11 || op == 2'b00) ? 16 : 8;
			for (int j = 0; j < len && p + j < n; j++) begin
				if (flt) e.rx[31-p-j] = 1'b0;
				else if (j < 6) e.rx[31-p-j] = 1'b1;
				else if (j == 6 || !ok) e.rx[31-p-j] = ok;
				else e.rx[31-p-j] = (op == 2'b11) ? model[s][15-j] : 1'b1;
			end
			if (ok && p + len <= n) begin
				case (op)
					2'b00: model[s] = {tx[24-p], tx[23-p -: 8]};
					2'b01: if (model[s] < 9'h100) model[s] = model[s] + 9'h001;
					2'b10: if (model[s] != 9'h000) model[s] = model[s] - 9'h001;
					default: ;
				endcase
			end
			flt = !ok;
			p += len;
		end
		e.flag = !flt;
		e.regs = model;
		exp_q.push_back(e);
		i_qpsd_spi_host.frame(tx, n, hv);
	endtask : send

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk_i) begin
		if (done === 1'b1 && exp_q.size() > 0) begin
			mon_e = exp_q.pop_front();
			check(rx, mon_e.rx, "serial out");
			check(32'(hv_cmd), 32'(mon_e.hv), "select level");
			if (mon_e.n % 8 == 0) check(32'(flag), 32'(mon_e.flag), "fault flag");
			for (int r = 0; r < 6; r++) check(32'(regs_seen[r]), 32'(mon_e.regs[r]), "reg");
		end
	end

	// ceiling sits well above the roughly 11300 cycles the sequence needs
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 40000) begin
			fails++;
			close_out();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] tx_tab [9] = '{32'h03FF_0400, 32'h0C00_0000, 32'h10FF_1414, 32'h1418_1818,
			32'h6000_6800, 32'h4471_5500, 32'h7122_0000, 32'h7033_7000, 32'hA15A_AC00};
		int n_tab [9] = '{24, 16, 32, 32, 24, 24, 12, 20, 32};
		rst_b_i = 1'b0;
		void'($urandom(42824));
		repeat (10) @(negedge clk_i);
		rst_b_i = 1'b1;
		repeat (4) @(negedge clk_i);
		// every location and operation code, random payload and select level
		for (int c = 0; c < 64; c++) begin
			send({c[5:0], 2'($urandom()), 8'($urandom()), 16'h0000}, 16, 1'($urandom()));
		end
		// saturation, back-to-back, fault mid-frame, partial frames, stray clocks
		for (int i = 0; i < 9; i++) begin
			if (i == 8) i_qpsd_spi_host.stray_clocks(5);
			send(tx_tab[i], n_tab[i], i[0]);
		end
		// a second reset mid-run must bring every register back to zero
		rst_b_i = 1'b0;
		model = '0;
		repeat (3) @(negedge clk_i);
		rst_b_i = 1'b1;
		repeat (4) @(negedge clk_i);
		send(32'h7C00_0000, 16, 1'b0);
		repeat (5) @(negedge clk_i);
		close_out();
	end
endmodule : qpsd_cmd_decoder_tb
